// file: bench/twid_dec_checker.sv
// Checker of decoder ports: load fields, holding, cycle spacing.
// Assumes it is bound to twid_decoder.
`timescale 1ns/10ps
module twid_dec_checker (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [11:0] I_WORD,
  input wire logic I_TEST_TRUE,
  input wire twid_pkg::twid_cat_t O_CAT,
  input wire logic [5:0] O_OPCODE,
  input wire logic O_DEST_FILE,
  input wire logic O_DEST_ACC,
  input wire logic [2:0] O_BIT_SEL,
  input wire logic [6:0] O_FILE,
  input wire logic [8:0] O_LIT,
  input wire logic O_LIT9,
  input wire logic O_VALID,
  input wire logic O_FLUSH,
  input wire logic O_CYCLE_START
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  // A fresh word sits on the outputs; the word itself was sampled one edge back.
  wire logic ld = O_CYCLE_START && O_VALID;
  wire logic byt = O_CAT == twid_pkg::TWID_CAT_BYTE;
  wire logic bt = O_CAT == twid_pkg::TWID_CAT_BIT;
  cycle_four_a: assert property (O_CYCLE_START |=> !O_CYCLE_START [*3] ##1 O_CYCLE_START)
    else $error("Cycle start spacing wrong.");
  hold_fields_a: assert property (!O_CYCLE_START |-> $stable({O_CAT, O_OPCODE, O_FILE, O_LIT, O_BIT_SEL}))
    else $error("Fields moved inside a cycle.");
  cat_class_a: assert property (ld |-> byt == ($past(I_WORD[11:10]) == 2'b00) && bt == ($past(I_WORD[11:10]) == 2'b01))
    else $error("Wrong category.");
  byte_fields_a: assert property (ld && byt |-> {O_OPCODE, O_DEST_FILE, O_FILE[4:0]} == $past(I_WORD))
    else $error("Byte fields wrong.");
  bit_fields_a: assert property (ld && bt |-> {O_OPCODE[3:0], O_BIT_SEL, O_FILE[4:0]} == $past(I_WORD))
    else $error("Bit fields wrong.");
  lit_fields_a: assert property (ld && !byt && !bt && !O_LIT9 |-> {O_OPCODE[3:0], O_LIT[7:0]} == $past(I_WORD))
    else $error("Literal fields wrong.");
  jump_fields_a: assert property (ld && O_LIT9 |-> {O_OPCODE[2:0], O_LIT} == $past(I_WORD))
    else $error("Jump fields wrong.");
  dest_sel_a: assert property (byt ? (O_DEST_ACC ^ O_DEST_FILE) : !(O_DEST_ACC || O_DEST_FILE))
    else $error("Destination select wrong.");
  file_range_a: assert property (O_FILE[6:5] == 2'b00 && (byt || bt || O_FILE == 7'h00))
    else $error("File address out of range.");
  stretch_a: assert property (ld && (O_LIT9 || $past(I_TEST_TRUE)) |-> ##4 O_FLUSH && !O_VALID)
    else $error("Missing second cycle.");
endmodule
bind twid_decoder twid_dec_checker twid_dec_checker_inst (.I_SYS_CLK, .I_RESET, .I_WORD, .I_TEST_TRUE,
  .O_CAT, .O_OPCODE, .O_DEST_FILE, .O_DEST_ACC, .O_BIT_SEL, .O_FILE, .O_LIT, .O_LIT9, .O_VALID,
  .O_FLUSH, .O_CYCLE_START);

// file: bench/twid_decoder_tb_top.sv
// Self-checking bench: fixed program, one task a scenario.
// Assumes twid_prog_mem feeds words and the checker is bound.
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module twid_decoder_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] wd;
  logic tt, df, da, l9, vld, fl, cs;
  twid_pkg::twid_cat_t cat, ec;
  logic [5:0] opc;
  logic [2:0] bs;
  logic [6:0] fa;
  logic [8:0] lit;
  int fails = 0;
  int cmp_count = 0;
  // Bit 12 is the test result handed with the word.
  logic [12:0] prog [0:10] = '{13'h01E5, 13'h01DF, 13'h12FF, 13'h07EA, 13'h04A1, 13'h16C3,
    13'h0CA5, 13'h0BFF, 13'h0A00, 13'h09F0, 13'h0FFF};
  twid_decoder twid_decoder_inst (.I_SYS_CLK(clk), .I_RESET(rst), .I_WORD(wd), .I_TEST_TRUE(tt),
    .O_CAT(cat), .O_OPCODE(opc), .O_DEST_FILE(df), .O_DEST_ACC(da), .O_BIT_SEL(bs), .O_FILE(fa),
    .O_LIT(lit), .O_LIT9(l9), .O_VALID(vld), .O_FLUSH(fl), .O_CYCLE_START(cs));
  twid_prog_mem twid_prog_mem_inst (.i_clk(clk), .i_adv(cs && vld), .o_word(wd), .o_test(tt));
  initial begin
    forever #5 clk = ~clk;
  end
  // Waits for word i to load, checks its fields, then the next cycle.
  task automatic run(input int i);
    logic [11:0] w;
    logic [5:0] o;
    logic s;
    int n;
    w = prog[i][11:0];
    n = 0;
    while (!(cs && vld) && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("load", 1'b1, cs && vld)
    ec = w[11:10] == 2'b00 ? twid_pkg::TWID_CAT_BYTE : (w[11] ? twid_pkg::TWID_CAT_LIT : twid_pkg::TWID_CAT_BIT);
    `CHK("cat", ec, cat)
    if (!w[11]) `CHK("file", {2'b00, w[4:0]}, fa)
    else `CHK("file", 7'h00, fa)
    if (w[11:10] == 2'b00) begin
      `CHK("op", w[11:6], opc)
      `CHK("dest", {w[5], ~w[5]}, {df, da})
    end else if (!w[11]) begin
      `CHK("op", {2'b00, w[11:8]}, opc)
      `CHK("bsel", w[7:5], bs)
    end else if (w[11:9] == 3'h5) begin
      `CHK("op", {3'b000, w[11:9]}, opc)
      `CHK("lit", {1'b1, w[8:0]}, {l9, lit})
    end else begin
      `CHK("op", {2'b00, w[11:8]}, opc)
      `CHK("lit", {2'b00, w[7:0]}, {l9, lit})
    end
    o = opc;
    s = prog[i][12] || w[11:9] == 3'h5 || w[11:8] == 4'h9;
    repeat (4) @(posedge clk);
    #1;
    `CHK("next", {1'b1, s, !s}, {cs, fl, vld})
    if (s) `CHK("hold", o, opc)
  endtask
  task automatic t_byte;
    run(0); run(1); run(2);
    $display("byte test done");
  endtask
  task automatic t_bit;
    run(3); run(4); run(5);
    $display("bit test done");
  endtask
  task automatic t_lit;
    run(6); run(7); run(8); run(9); run(10);
    $display("literal test done");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole program needs well under a microsecond; this cuts a hang.
  initial begin
    #5000;
    fails++;
    final_report;
  end
  initial begin
    for (int k = 0; k < 16; k++) twid_prog_mem_inst.rom[k] = (k < 11) ? prog[k] : 13'h0000;
    repeat (5) @(posedge clk);
    #1;
    `CHK("rst", {twid_pkg::TWID_CAT_LIT, 1'b0}, {cat, vld})
    rst = 1'b0;
    t_byte;
    t_bit;
    t_lit;
    final_report;
  end
endmodule

// file: bench/twid_prog_mem.sv
// Program memory model: one word and test flag per loaded cycle.
// Assumes the bench fills rom before reset is released.
`timescale 1ns/10ps
module twid_prog_mem (
  input wire logic i_clk,
  input wire logic i_adv,
  output logic [11:0] o_word,
  output logic o_test
);
  logic [12:0] rom [0:15];
  logic [3:0] pc = 4'h0;
  // Step 1 ns after the edge that follows a load edge, so the next word is ready long before Q4.
  always @(posedge i_clk) begin
    if (i_adv) #1 pc <= pc + 4'h1;
  end
  assign {o_test, o_word} = rom[pc];
endmodule

// file: rtl/twid_decoder.sv
// Top of the twelve-bit instruction decoder: latches one word per cycle,
// presents decoded fields, and stretches to two cycles when needed.
// Assumes program memory holds I_WORD valid at the end of each cycle and
// the datapath reports a true conditional test on I_TEST_TRUE.
//
// Overview of operation
// - Take one 12-bit word, split it.
// - Classify into byte, bit, literal category.
// - Byte format gives file address, destination.
// - Destination zero accumulator, one file register.
// - Bit format gives bit selector, file.
// - Literal operand eight or nine bits wide.
// - File addresses within 0x00 to 0x1F.
// - Don't-care bits never change decoding.
// - One cycle, two on skip or jump.
// - Four oscillator periods per instruction cycle.
// - Byte opcode 11-6, dest 5, file 4-0.
// - Bit opcode 11-8, selector 7-5, file.
// - Literal opcode 11-8, immediate 7-0.
// - Jump opcode 11-9, target 8-0.
`timescale 1ns/10ps
`include "twid_cfg.svh"

module twid_decoder (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [11:0] I_WORD,
  input wire logic I_TEST_TRUE,
  output twid_pkg::twid_cat_t O_CAT,
  output logic [5:0] O_OPCODE,
  output logic O_DEST_FILE,
  output logic O_DEST_ACC,
  output logic [2:0] O_BIT_SEL,
  output logic [6:0] O_FILE,
  output logic [8:0] O_LIT,
  output logic O_LIT9,
  output logic O_VALID,
  output logic O_FLUSH,
  output logic O_CYCLE_START
);

  logic cycle_end;
  twid_pkg::twid_cat_t next_cat;
  logic [5:0] next_opcode;
  logic next_dest_file;
  logic [2:0] next_bit_sel;
  logic [4:0] next_file;
  logic [8:0] next_lit;
  logic next_lit9;
  logic next_pc_change;
  logic pending_second;

  ////////////////////////////////////////////////////////////////////////////
  // four-phase sequencer.
  twid_phase_gen u_phase (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .o_phase(),
    .o_cycle_end(cycle_end)
  );

  twid_field_split u_split (
    .i_word(I_WORD),
    .o_cat(next_cat),
    .o_opcode(next_opcode),
    .o_dest_file(next_dest_file),
    .o_bit_sel(next_bit_sel),
    .o_file(next_file),
    .o_lit(next_lit),
    .o_lit9(next_lit9),
    .o_pc_change(next_pc_change)
  );

  // Decides whether the coming cycle is the second of a stretched one.
  function automatic logic next_second();
    next_second = pending_second;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // load fields once per cycle.
  // Loading only at the cycle boundary keeps them stable for four clocks;
  // during the second cycle of a stretched instruction the fields hold.
  // registered category.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CAT <= twid_pkg::TWID_CAT_LIT;
      O_OPCODE <= `TWID_RST_OPCODE;
      O_BIT_SEL <= 3'h0;
      O_LIT <= `TWID_RST_LIT;
      O_LIT9 <= 1'b0;
    end else if (cycle_end && !next_second()) begin
      O_CAT <= next_cat;
      O_OPCODE <= next_opcode;
      O_BIT_SEL <= next_bit_sel;
      O_LIT <= next_lit;
      O_LIT9 <= next_lit9;
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_FILE <= {2'h0, `TWID_RST_FILE};
      O_DEST_FILE <= 1'b0;
      O_DEST_ACC <= 1'b0;
    end else if (cycle_end && !next_second()) begin
      O_FILE <= {2'h0, next_file};
      O_DEST_FILE <= (next_cat == twid_pkg::TWID_CAT_BYTE) && next_dest_file;
      O_DEST_ACC <= (next_cat == twid_pkg::TWID_CAT_BYTE) && !next_dest_file;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stretch on test or jump.
  // A jump or call is known from the word; a skip only when the datapath
  // sees its test come true, so that is sampled at the cycle end.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pending_second <= 1'b0;
    end else if (cycle_end) begin
      if (pending_second) begin
        pending_second <= 1'b0;
      end else begin
        pending_second <= next_pc_change || I_TEST_TRUE;
      end
    end
  end

  // Valid marks a fresh instruction; flush marks the idle second cycle.
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_VALID <= 1'b0;
      O_FLUSH <= 1'b0;
      O_CYCLE_START <= 1'b0;
    end else begin
      O_CYCLE_START <= cycle_end;
      if (cycle_end) begin
        O_VALID <= !pending_second;
        // A flush cycle is exactly the second half of a stretched instruction.
        O_FLUSH <= pending_second;
      end
    end
  end

  // don't-care bits ignored.
  // The splitter zeroes every position a format does not define, so both
  // values of an x bit give identical outputs.

endmodule

// file: rtl/twid_field_split.sv
// Combinational splitter of a 12-bit word into category and fields.
// Assumes the word is stable while it is read.
`timescale 1ns/10ps
`include "twid_cfg.svh"

module twid_field_split (
  input wire logic [11:0] i_word,
  output twid_pkg::twid_cat_t o_cat,
  output logic [5:0] o_opcode,
  output logic o_dest_file,
  output logic [2:0] o_bit_sel,
  output logic [4:0] o_file,
  output logic [8:0] o_lit,
  output logic o_lit9,
  output logic o_pc_change
);

  // Category from the top nibble: 0-3 byte, 4-7 bit, 8-F literal/control.
  function automatic twid_pkg::twid_cat_t cat_of(input logic [3:0] top);
    if (top <= `TWID_TOP_BYTE_MAX) begin
      cat_of = twid_pkg::TWID_CAT_BYTE;
    end else if (top <= `TWID_TOP_BIT_MAX) begin
      cat_of = twid_pkg::TWID_CAT_BIT;
    end else begin
      cat_of = twid_pkg::TWID_CAT_LIT;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // don't-care bits ignored.
  // Field extraction; unused positions are zeroed so don't-care bits vanish.
  always_comb begin
    o_cat = cat_of(i_word[11:8]);
    o_opcode = 6'h00;
    o_dest_file = 1'b0;
    o_bit_sel = 3'h0;
    o_file = i_word[`TWID_FILE_HI:`TWID_FILE_LO];
    o_lit = 9'h000;
    o_lit9 = 1'b0;
    o_pc_change = 1'b0;
    unique case (o_cat)
      twid_pkg::TWID_CAT_BYTE: begin
        o_opcode = i_word[`TWID_BYTE_OP_HI:`TWID_BYTE_OP_LO];
        o_dest_file = i_word[`TWID_DEST_BIT];
      end
      twid_pkg::TWID_CAT_BIT: begin
        o_opcode = {2'h0, i_word[`TWID_BIT_OP_HI:`TWID_BIT_OP_LO]};
        o_bit_sel = i_word[`TWID_BSEL_HI:`TWID_BSEL_LO];
      end
      twid_pkg::TWID_CAT_LIT: begin
        o_file = 5'h00;
        if (i_word[`TWID_JMP_OP_HI:`TWID_JMP_OP_LO] == `TWID_JMP_TOP3) begin
          o_opcode = {3'h0, i_word[`TWID_JMP_OP_HI:`TWID_JMP_OP_LO]};
          o_lit = i_word[`TWID_JMP_HI:`TWID_JMP_LO];
          o_lit9 = 1'b1;
          o_pc_change = 1'b1;
        end else begin
          o_opcode = {2'h0, i_word[`TWID_LIT_OP_HI:`TWID_LIT_OP_LO]};
          o_lit = {1'b0, i_word[`TWID_LIT_HI:`TWID_LIT_LO]};
          // Call (top nibble 9) also loads the program counter.
          o_pc_change = (i_word[11:8] == 4'h9);
        end
      end
      default: begin
        o_opcode = 6'h00;
      end
    endcase
  end

endmodule

// file: rtl/twid_phase_gen.sv
// Four-phase sequencer that marks instruction cycle boundaries.
// Assumes one oscillator period per clock edge of i_clk.
`timescale 1ns/10ps
`include "twid_cfg.svh"

module twid_phase_gen (
  input wire logic i_clk,
  input wire logic i_reset,
  output twid_pkg::twid_phase_t o_phase,
  output logic o_cycle_end
);

  ////////////////////////////////////////////////////////////////////////////
  // Rotate one-hot phase; four clocks per instruction cycle.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_phase <= twid_pkg::TWID_PH_Q1;
    end else begin
      unique case (o_phase)
        twid_pkg::TWID_PH_Q1: o_phase <= twid_pkg::TWID_PH_Q2;
        twid_pkg::TWID_PH_Q2: o_phase <= twid_pkg::TWID_PH_Q3;
        twid_pkg::TWID_PH_Q3: o_phase <= twid_pkg::TWID_PH_Q4;
        twid_pkg::TWID_PH_Q4: o_phase <= twid_pkg::TWID_PH_Q1;
        default: o_phase <= twid_pkg::TWID_PH_Q1;
      endcase
    end
  end

  // Flags the last clock of the cycle so the decoder can load on it.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cycle_end <= 1'b0;
    end else begin
      o_cycle_end <= (o_phase == twid_pkg::TWID_PH_Q3);
    end
  end

endmodule

// file: shared/twid_cfg.svh
// Constants for the twelve-bit instruction decoder: field positions and timing.
// Assumes nothing; include by bare name.
`ifndef TWID_CFG_SVH
`define TWID_CFG_SVH

// Field positions inside the 12-bit word.
`define TWID_WORD_W 12
`define TWID_BYTE_OP_HI 11
`define TWID_BYTE_OP_LO 6
`define TWID_DEST_BIT 5
`define TWID_FILE_HI 4
`define TWID_FILE_LO 0
`define TWID_BIT_OP_HI 11
`define TWID_BIT_OP_LO 8
`define TWID_BSEL_HI 7
`define TWID_BSEL_LO 5
`define TWID_LIT_OP_HI 11
`define TWID_LIT_OP_LO 8
`define TWID_LIT_HI 7
`define TWID_LIT_LO 0
`define TWID_JMP_OP_HI 11
`define TWID_JMP_OP_LO 9
`define TWID_JMP_HI 8
`define TWID_JMP_LO 0

// Register file address range.
`define TWID_FILE_MIN 7'h00
`define TWID_FILE_MAX 7'h7F

// Category boundaries on the top nibble.
`define TWID_TOP_BYTE_MAX 4'h3
`define TWID_TOP_BIT_MAX 4'h7
`define TWID_JMP_TOP3 3'h5

// Clock periods per instruction cycle.
`define TWID_OSC_PER_CYCLE 4
`define TWID_PHASE_W 2

// Nominal single-cycle time at a 4 MHz oscillator, in ns.
`define TWID_REF_OSC_MHZ 4
`define TWID_REF_CYCLE_NS ((1000 * `TWID_OSC_PER_CYCLE) / `TWID_REF_OSC_MHZ)

// Reset values of the outputs.
`define TWID_RST_OPCODE 6'h00
`define TWID_RST_FILE 5'h00
`define TWID_RST_LIT 9'h000

`endif

// file: shared/twid_pkg.sv
// Types shared by the twelve-bit instruction decoder files.
// Assumes twid_cfg.svh supplies the numeric constants.
package twid_pkg;

  // Format category, one-hot.
  typedef enum logic [2:0] {
    TWID_CAT_BYTE = 3'h1,
    TWID_CAT_BIT = 3'h2,
    TWID_CAT_LIT = 3'h4
  } twid_cat_t;

  // Phase within an instruction cycle, one-hot.
  typedef enum logic [3:0] {
    TWID_PH_Q1 = 4'h1,
    TWID_PH_Q2 = 4'h2,
    TWID_PH_Q3 = 4'h4,
    TWID_PH_Q4 = 4'h8
  } twid_phase_t;

endpackage
